// File: design/cid_pkg.sv
package cid_pkg;

  // System clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Register map, byte addresses on the plain register port
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h04;

  // Control register fields
  localparam int unsigned CTRL_INV_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_SEL_LSB = 4;
  localparam logic CTRL_INV_RST = 1'b0;
  localparam logic [3:0] CTRL_SEL_RST = 4'h0;

  // Status register fields
  localparam int unsigned STAT_OUT_BIT = 0;
  localparam int unsigned STAT_COND_BIT = 1;
  localparam int unsigned STAT_ARMED_BIT = 2;

  // Filter behaviour select; 2'b11 falls back to bypass
  typedef enum logic [1:0] {
    CID_BYPASS = 2'b00,
    CID_AFTER = 2'b01,
    CID_BEFORE = 2'b10,
    CID_SPARE = 2'b11
  } cid_mode_t;

  // Debounce times in ns, shortest and longest fixed, ladder between
  localparam int unsigned DEB_NUM = 16;
  localparam int unsigned DEB_MIN_NS = 500;
  localparam int unsigned DEB_MAX_NS = 25_500_000;
  localparam int unsigned DEB_TIME_NS [DEB_NUM] = '{
    DEB_MIN_NS, 1_000, 2_000, 5_000, 10_000, 20_000, 50_000, 100_000,
    200_000, 500_000, 1_000_000, 2_000_000, 5_000_000, 10_000_000,
    20_000_000, DEB_MAX_NS
  };

  // Longest count in cycles decides the counter width
  localparam int unsigned DEB_MAX_CYC =
    (DEB_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = $clog2(DEB_MAX_CYC + 1);

endpackage

// File: design/cid_filter.sv
`timescale 1ns/1ps
module cid_filter
  import cid_pkg::*;
#(
  parameter int unsigned TIME_DIV = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Signal path
  input wire logic sig_in,
  output logic sig_out
);

  // Whole state of the channel
  typedef struct packed {
    logic inv;
    logic [1:0] mode;
    logic [3:0] sel;
    logic prev;
    logic [CNT_W-1:0] cnt;
    logic out;
    logic [31:0] rdata;
  } cid_state_t;

  cid_state_t s_reg;
  cid_state_t s_next;
  logic [CNT_W-1:0] lim_tbl [DEB_NUM];
  logic [CNT_W-1:0] lim;
  logic cond;
  logic armed;
  logic held;

  // Cycle count per setting, rounded up, then divided by TIME_DIV rounding down, never below one cycle
  function automatic int unsigned deb_cycles(int unsigned idx);
    int unsigned c;
    c = (DEB_TIME_NS[idx] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    c = c / TIME_DIV;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction

  // Constant limit table, one entry per debounce setting
  for (genvar i = 0; i < DEB_NUM; i++) begin : g_lim
    assign lim_tbl[i] = CNT_W'(deb_cycles(i));
  end

  assign lim = lim_tbl[s_reg.sel];
  // Inverter sits ahead of every path so edge sense holds in all modes
  assign cond = sig_in ^ s_reg.inv;
  // Input was stable for the full time before this cycle
  assign armed = (s_reg.cnt >= lim);
  assign held = (s_next.cnt >= lim);

  // Next state: stability counter, filter decision, register port
  always_comb begin
    s_next = s_reg;
    // Restart on any change; saturate so a long quiet input never wraps
    if (cond != s_reg.prev) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt < lim) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
    s_next.prev = cond;
    case (cid_mode_t'(s_reg.mode))
      CID_AFTER: begin
        // Only a level held for the whole time reaches the output
        if (held) begin
          s_next.out = cond;
        end
      end
      CID_BEFORE: begin
        // First edge after a quiet spell passes, bounces behind it do not
        if (armed && (cond != s_reg.out)) begin
          s_next.out = cond;
        end
      end
      default: begin
        s_next.out = cond;
      end
    endcase
    // Control write; a new time select takes effect on the next cycle
    if (reg_wr && (reg_addr == CTRL_OFFS)) begin
      s_next.inv = reg_wdata[CTRL_INV_BIT];
      s_next.mode = reg_wdata[CTRL_MODE_LSB +: 2];
      s_next.sel = reg_wdata[CTRL_SEL_LSB +: 4];
    end
    // Read data stand for one cycle only, zero otherwise
    s_next.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == CTRL_OFFS) begin
        s_next.rdata[CTRL_INV_BIT] = s_reg.inv;
        s_next.rdata[CTRL_MODE_LSB +: 2] = s_reg.mode;
        s_next.rdata[CTRL_SEL_LSB +: 4] = s_reg.sel;
      end else if (reg_addr == STATUS_OFFS) begin
        s_next.rdata[STAT_OUT_BIT] = s_reg.out;
        s_next.rdata[STAT_COND_BIT] = s_reg.prev;
        s_next.rdata[STAT_ARMED_BIT] = armed;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{inv: CTRL_INV_RST, mode: CID_BYPASS, sel: CTRL_SEL_RST,
                 prev: 1'b0, cnt: '0, out: 1'b0, rdata: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sig_out = s_reg.out;
  assign reg_rdata = s_reg.rdata;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Limit always within the documented span
  property p_lim_range;
    (lim >= 1) && (lim <= CNT_W'(DEB_MAX_CYC));
  endproperty
  a_lim_range: assert property (p_lim_range)
    else $error("debounce limit out of range");

  // Conditioned input is the raw input through the inverter
  property p_invert;
    ##1 s_reg.prev == ($past(sig_in) ^ $past(s_reg.inv));
  endproperty
  a_invert: assert property (p_invert)
    else $error("inverter stage wrong");

  // Control write lands in the mode field
  property p_mode_write;
    (reg_wr && reg_addr == CTRL_OFFS)
      |=> s_reg.mode == $past(reg_wdata[CTRL_MODE_LSB +: 2]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write lost");

  // Bypass follows conditioned input one cycle later, time ignored
  property p_bypass;
    (s_reg.mode == CID_BYPASS) |=> sig_out == $past(cond);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass path wrong");

  // Spare code acts as bypass, so no setting can leave the output stuck
  property p_spare_bypass;
    (s_reg.mode == CID_SPARE) |=> sig_out == $past(cond);
  endproperty
  a_spare_bypass: assert property (p_spare_bypass)
    else $error("spare mode not bypassed");

  // Control fields move only on a write to the control offset
  property p_ctrl_keep;
    !(reg_wr && reg_addr == CTRL_OFFS)
      |=> $stable({s_reg.inv, s_reg.mode, s_reg.sel});
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("control changed without write");

  // After mode: output changes only when the level has been held
  property p_after_hold;
    (s_reg.mode == CID_AFTER && !held) |=> $stable(sig_out);
  endproperty
  a_after_hold: assert property (p_after_hold)
    else $error("after mode moved without stability");

  // After mode: a level held for the full time is adopted
  sequence s_after_held;
    (s_reg.mode == CID_AFTER) && held;
  endsequence
  property p_after_follow;
    s_after_held |=> sig_out == $past(cond);
  endproperty
  a_after_follow: assert property (p_after_follow)
    else $error("after mode missed stable level");

  // Before mode: an edge after a quiet spell passes at once
  sequence s_before_edge;
    (s_reg.mode == CID_BEFORE) && armed && (cond != sig_out);
  endsequence
  property p_before_pass;
    s_before_edge |=> sig_out == $past(cond);
  endproperty
  a_before_pass: assert property (p_before_pass)
    else $error("before mode edge not passed");

  // Before mode: without a quiet spell the output is frozen
  property p_before_block;
    (s_reg.mode == CID_BEFORE && !armed) |=> $stable(sig_out);
  endproperty
  a_before_block: assert property (p_before_block)
    else $error("before mode not blocked");

  // Counter restarts on a change and climbs while the input stays
  property p_cnt_restart;
    (cond != s_reg.prev) |=> s_reg.cnt == '0;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart)
    else $error("counter not restarted");

  property p_cnt_climb;
    (cond == s_reg.prev && s_reg.cnt < lim && !reg_wr)
      |=> s_reg.cnt == $past(s_reg.cnt) + 1'b1;
  endproperty
  a_cnt_climb: assert property (p_cnt_climb)
    else $error("counter not counting clocks");

  // Read data stand only in the cycle after the strobe
  property p_rd_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");

endmodule

// File: tb/cid_partner.sv
`timescale 1ns/1ps
// Far side: raw input source and a rising-edge counter on the output
module cid_partner (
  // Clock
  input wire logic clk,
  // Filter link
  input wire logic sig_out,
  output logic sig_in
);
  int unsigned rises;
  logic last_out;
  initial begin
    sig_in = 1'b0;
    rises = 0;
    last_out = 1'b0;
  end
  // Counter side counts every accepted rising edge of the filtered line
  always @(posedge clk) begin
    if (sig_out === 1'b1 && last_out === 1'b0) rises <= rises + 1;
    last_out <= sig_out;
  end
  // Source holds a level for n samples; changes only right after an edge
  task automatic hold(input logic lv, input int n);
    sig_in <= lv;
    repeat (n) @(posedge clk);
  endtask
endmodule

// File: tb/tb_cid_filter.sv
`timescale 1ns/1ps
module tb_cid_filter;
  import cid_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, sig_in, sig_out;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int fails, checked, l0, l1;
  cid_filter #(.TIME_DIV(1)) dut_u (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sig_in(sig_in),
    .sig_out(sig_out));
  cid_partner part_u (.clk(clk), .sig_out(sig_out), .sig_in(sig_in));
  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Let the edge's register updates land before looking at the output
  task automatic chk_out(input logic exp);
    #1 chk({31'h0, sig_out}, {31'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #2_000_000;
    fails++;
    tally_and_finish;
  end
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    fails = 0;
    checked = 0;
    l0 = DEB_TIME_NS[0] / CLK_PERIOD_NS;
    l1 = DEB_TIME_NS[1] / CLK_PERIOD_NS;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Defaults, bypass, inversion and register refusals
    rd(CTRL_OFFS); chk(rv, 32'h0);
    part_u.hold(1'b1, 2); chk_out(1'b1);
    wr(CTRL_OFFS, 32'h1);
    part_u.hold(1'b1, 2); chk_out(1'b0);
    rd(STATUS_OFFS); chk(rv, 32'h0);
    wr(STATUS_OFFS, 32'hff);
    rd(8'h40); chk(rv, 32'h0);
    rd(CTRL_OFFS); chk(rv, 32'h1);
    $display("test bypass done");
    // After-stable mode, shortest time then the next one
    wr(CTRL_OFFS, 32'h2);
    part_u.hold(1'b0, l0 + 3);
    part_u.hold(1'b1, l0);
    part_u.hold(1'b0, l0 + 2); chk_out(1'b0);
    part_u.hold(1'b1, l0); chk_out(1'b0);
    part_u.hold(1'b1, 1); chk_out(1'b1);
    part_u.hold(1'b0, l0 + 1); chk_out(1'b0);
    wr(CTRL_OFFS, 32'h12);
    part_u.hold(1'b1, l1); chk_out(1'b0);
    part_u.hold(1'b1, 1); chk_out(1'b1);
    // Partner sees the last rise one edge late, after its own update
    @(posedge clk);
    #1 chk(32'(part_u.rises), 32'h3);
    rd(STATUS_OFFS); chk(rv, 32'h7);
    $display("test after done");
    // Before-stable mode: pass at once, then block until stable again
    wr(CTRL_OFFS, 32'h4);
    part_u.hold(1'b1, l0 + 2);
    part_u.hold(1'b0, 2); chk_out(1'b0);
    part_u.hold(1'b1, 2); chk_out(1'b0);
    part_u.hold(1'b0, l0 + 2);
    part_u.hold(1'b1, 2); chk_out(1'b1);
    $display("test before done");
    // Spare encoding falls back to bypass: short pulses pass
    wr(CTRL_OFFS, 32'h6);
    part_u.hold(1'b0, 2); chk_out(1'b0);
    part_u.hold(1'b1, 2); chk_out(1'b1);
    $display("test spare done");
    tally_and_finish;
  end
endmodule
